// [include/window_binding_regs.svh]
/*
 Register offsets, field positions, reset values and window class split for the
 window binding logic. Assumes inclusion by bare name, once per file.
*/
`ifndef WINDOW_BINDING_REGS_SVH
`define WINDOW_BINDING_REGS_SVH

`define BIND_SPACE       8'h6F
`define SYNC_SPACE       8'hEF
`define BIND_VALID_BIT   63
`define BIND_UNIT_HI     9
`define BIND_UNIT_LO     5
`define SYNC_VALUE_BIT   0
`define WIN_STEP_SHIFT   3
`define WIN_COUNT        20
`define WIN_BARRIER_CNT  4
`define BIND_RESET       64'h0000_0000_0000_0000

`endif

// [include/window_binding_pkg.sv]
/*
 Types shared by the window binding logic.
 Assumes the header of constants is included where offsets are needed.
*/
package window_binding_pkg;

   typedef logic [4:0] unit_t;

   // Core access request in the window or binding space
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        priv;
      logic [7:0]  space;
      logic [7:0]  addr;
      logic [63:0] wdata;
   } core_req_s;

   // Binding state of one window
   typedef struct packed {
      logic  bound;
      unit_t unit;
   } binding_s;

   typedef enum logic {
      CLASS_BARRIER,
      CLASS_POSTWAIT
   } win_class_e;

endpackage

// [verilog/unit_class_check.sv]
/*
 Checks a requested unit number against a window class.
 Assumes the unit count covers numbers 0 to 27; others do not exist.
*/
`include "window_binding_regs.svh"

module unit_class_check (
   // Request
   input  window_binding_pkg::unit_t      unit,
   input  window_binding_pkg::win_class_e win_class,
   // Result
   output logic                           accept
);

   wire is_barrier  = (unit <= 5'h03) ||
                      (unit >= 5'h10 && unit <= 5'h13);
   wire is_postwait = (unit >= 5'h04 && unit <= 5'h0B) ||
                      (unit >= 5'h14 && unit <= 5'h1B);

   // Nonexistent units fall in neither class
   assign accept = (win_class == window_binding_pkg::CLASS_BARRIER)
                   ? is_barrier
                   : is_postwait;

endmodule

// [verilog/window_decode.sv]
/*
 Decodes a window offset into a window index and its class.
 Assumes offsets arrive as the low address byte of the access.
*/
`include "window_binding_regs.svh"

module window_decode (
   // Address
   input  logic [7:0]                     addr,
   // Decoded window
   output logic [4:0]                     index,
   output logic                           hit,
   output window_binding_pkg::win_class_e win_class
);

   wire [4:0] slot = addr[7:`WIN_STEP_SHIFT];

   assign index = slot;
   // Aligned and within the twenty windows
   assign hit = (addr[2:0] == 3'h0) &&
                (slot < 5'(`WIN_COUNT));
   assign win_class = (slot < 5'(`WIN_BARRIER_CNT))
                      ? window_binding_pkg::CLASS_BARRIER
                      : window_binding_pkg::CLASS_POSTWAIT;

endmodule

// [verilog/window_binding.sv]
/*
 Per-core window binding table and window access routing to sync units.
 Assumes one access per cycle from the core; unit state lives outside.
*/
`include "window_binding_regs.svh"

module window_binding #(
   parameter int NUM_UNITS = 28
) (
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          rstn,
   // Core access
   input  wire window_binding_pkg::core_req_s req,
   output logic                               ack,
   output logic [63:0]                        rdata,
   // Sync units
   input  wire logic [NUM_UNITS-1:0]          unit_last_sync,
   output logic                               status_we,
   output window_binding_pkg::unit_t          status_unit,
   output logic                               status_value
);

   window_binding_pkg::binding_s table_q [`WIN_COUNT];

   logic [4:0]                     win_idx;
   logic                           win_hit;
   window_binding_pkg::win_class_e win_class;
   logic                           class_ok;

   window_decode u_decode (
      .addr      (req.addr),
      .index     (win_idx),
      .hit       (win_hit),
      .win_class (win_class)
   );

   wire window_binding_pkg::unit_t new_unit =
      req.wdata[`BIND_UNIT_HI:`BIND_UNIT_LO];

   unit_class_check u_check (
      .unit      (new_unit),
      .win_class (win_class),
      .accept    (class_ok)
   );

   wire in_bind = req.valid && req.space == `BIND_SPACE && win_hit;
   wire in_sync = req.valid && req.space == `SYNC_SPACE && win_hit;
   // Binding space needs privilege; window space is open to all
   wire bind_ok = in_bind && req.priv;
   wire new_valid = req.wdata[`BIND_VALID_BIT];
   wire bind_wr = bind_ok && req.write;
   wire window_binding_pkg::binding_s cur = table_q[win_idx];

   // Rejected binding writes fall silently; no exception path exists
   wire do_bind = bind_wr && new_valid && class_ok;
   wire do_free = bind_wr && !new_valid;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `WIN_COUNT; i++) begin
            table_q[i] <= '0;
         end
      end else if (do_bind) begin
         table_q[win_idx] <= '{bound: 1'b1, unit: new_unit};
      end else if (do_free) begin
         table_q[win_idx] <= '{bound: 1'b0, unit: cur.unit};
      end
   end

   // Status writes pass only through bound windows
   wire sync_wr = in_sync && req.write && cur.bound;
   wire in_range = 32'(cur.unit) < NUM_UNITS;

   assign status_we    = sync_wr;
   assign status_unit  = cur.unit;
   assign status_value = req.wdata[`SYNC_VALUE_BIT];
   assign ack          = in_bind ? req.priv : in_sync;

   logic [63:0] rdata_d;
   always_comb begin
      rdata_d = 64'h0000_0000_0000_0000;
      if (bind_ok) begin
         rdata_d[`BIND_VALID_BIT] = cur.bound;
         rdata_d[`BIND_UNIT_HI:`BIND_UNIT_LO] = cur.unit;
      end else if (in_sync && cur.bound && in_range) begin
         rdata_d[`SYNC_VALUE_BIT] = unit_last_sync[cur.unit];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata <= 64'h0000_0000_0000_0000;
      end else if (req.valid && !req.write) begin
         rdata <= rdata_d;
      end
   end

   // is kept by the unit itself after each status_we pulse.

   a_reset_unbound: assert property (
      @(posedge clock) $rose(rstn) |-> !table_q[0].bound)
      else $error("window bound right after reset");

   a_bind_takes: assert property (
      @(posedge clock) disable iff (!rstn)
      do_bind |=> table_q[$past(win_idx)].bound)
      else $error("accepted binding not stored");

   a_class_reject: assert property (
      @(posedge clock) disable iff (!rstn)
      bind_wr && new_valid && !class_ok |=>
      table_q[$past(win_idx)] == $past(cur))
      else $error("rejected binding changed table");

   a_free_clears: assert property (
      @(posedge clock) disable iff (!rstn)
      do_free |=> !table_q[$past(win_idx)].bound)
      else $error("release did not clear binding");

   a_unbound_drop: assert property (
      @(posedge clock) disable iff (!rstn)
      status_we |-> cur.bound && in_sync)
      else $error("status write through unbound window");

   a_user_no_bind: assert property (
      @(posedge clock) disable iff (!rstn)
      in_bind && req.write && !req.priv |=>
      table_q[$past(win_idx)] == $past(cur))
      else $error("user changed a binding");

   a_bind_readback: assert property (
      @(posedge clock) disable iff (!rstn)
      bind_ok && !req.write |=>
      rdata[`BIND_VALID_BIT] == $past(cur.bound))
      else $error("binding read wrong valid");

   a_postwait_unit: assert property (
      @(posedge clock) disable iff (!rstn)
      do_bind && win_class == window_binding_pkg::CLASS_POSTWAIT |->
      (new_unit >= 5'h04 && new_unit <= 5'h0B) ||
      (new_unit >= 5'h14 && new_unit <= 5'h1B))
      else $error("post-wait window took wrong unit");

endmodule

// [tb/window_binding_tb.sv]
/*
 Self-checking bench for the window binding logic.
 Assumes one request per cycle, read data one edge later.
*/
`include "window_binding_regs.svh"

module window_binding_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                          clock = 1'b0;
   logic                          rstn = 1'b0;
   window_binding_pkg::core_req_s req = '0;
   logic [27:0]                   lsync = 28'h0AC_35F2;
   logic                          ack;
   logic                          status_we;
   logic                          status_value;
   logic [63:0]                   rdata;
   window_binding_pkg::unit_t     status_unit;
   logic [7:0]                    seen;
   logic [7:0]                    bad_ad [6] = '{8'h00, 8'h00, 8'h20,
                                                 8'h20, 8'h08, 8'h28};
   logic [4:0]                    bad_un [6] = '{5'h04, 5'h14, 5'h00,
                                                 5'h10, 5'h1C, 5'h1F};
   int                            n_fail = 0;
   int                            n_checks = 0;
   int                            u;

   always #2 clock = ~clock;

   window_binding dut (
      .clock(clock), .rstn(rstn), .req(req), .ack(ack), .rdata(rdata),
      .unit_last_sync(lsync), .status_we(status_we),
      .status_unit(status_unit), .status_value(status_value)
   );

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One access; combinational answers sampled mid-cycle
   task automatic acc(input logic wr, input logic pr, input logic [7:0] sp,
                      input logic [7:0] ad, input logic [63:0] wd);
      @(negedge clock);
      req = '{1'b1, wr, pr, sp, ad, wd};
      #1 seen = {ack, status_we, status_value, status_unit};
      @(negedge clock);
      req.valid = 1'b0;
   endtask

   function automatic logic [63:0] bv(input logic [4:0] un);
      bv = 64'h0000_0000_0000_0000;
      bv[`BIND_VALID_BIT] = 1'b1;
      bv[`BIND_UNIT_HI:`BIND_UNIT_LO] = un;
   endfunction

   task automatic bind_wr(input logic [7:0] ad, input logic [63:0] wd);
      acc(1'b1, 1'b1, `BIND_SPACE, ad, wd);
   endtask

   task automatic bind_rd(input logic [7:0] ad, input logic [63:0] exp);
      acc(1'b0, 1'b1, `BIND_SPACE, ad, 64'h0000_0000_0000_0000);
      chk(rdata, exp);
   endtask

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(negedge clock);
      rstn = 1'b1;
      for (int i = 0; i < 20; i++) begin
         bind_rd(8'(i * 8), 64'h0000_0000_0000_0000);
      end
      // Units taken as set up and consistent
      // Windows 0-3 to units 0-3, 4-11 to 4-11, 12-19 to 20-27
      for (int i = 0; i < 20; i++) begin
         u = (i < 12) ? i : i + 8;
         bind_wr(8'(i * 8), bv(5'(u)));
         bind_rd(8'(i * 8), bv(5'(u)));
      end
      // Wrong class or missing unit leaves the old binding
      for (int k = 0; k < 6; k++) begin
         bind_wr(bad_ad[k], bv(bad_un[k]));
         bind_rd(bad_ad[k], bv(5'(bad_ad[k] >> 3)));
      end
      bind_wr(8'h10, bv(5'h10));
      bind_rd(8'h10, bv(5'h10));
      bind_wr(8'h30, bv(5'h14));
      bind_rd(8'h30, bv(5'h14));
      acc(1'b0, 1'b0, `SYNC_SPACE, 8'h08, 64'h0000_0000_0000_0000);
      chk(rdata, 64'(lsync[1]));
      lsync = ~lsync;
      acc(1'b0, 1'b0, `SYNC_SPACE, 8'h60, 64'h0000_0000_0000_0000);
      chk(rdata, 64'(lsync[20]));
      // Idle cycle between accesses orders store before load
      acc(1'b1, 1'b0, `SYNC_SPACE, 8'h08, 64'hFFFF_FFFF_FFFF_FFFE);
      chk(64'(seen), 64'h0000_0000_0000_00C1);
      acc(1'b1, 1'b0, `SYNC_SPACE, 8'h60, 64'h0000_0000_0000_0001);
      chk(64'(seen), 64'h0000_0000_0000_00F4);
      acc(1'b1, 1'b0, `BIND_SPACE, 8'h08, bv(5'h02));
      chk(64'(seen[7]), 64'h0000_0000_0000_0000);
      bind_rd(8'h08, bv(5'h01));
      bind_wr(8'h08, 64'h0000_0000_0000_0000);
      acc(1'b0, 1'b1, `BIND_SPACE, 8'h08, 64'h0000_0000_0000_0000);
      chk(64'(rdata[63]), 64'h0000_0000_0000_0000);
      acc(1'b1, 1'b0, `SYNC_SPACE, 8'h08, 64'h0000_0000_0000_0001);
      chk(64'(seen[6]), 64'h0000_0000_0000_0000);
      acc(1'b1, 1'b1, `BIND_SPACE, 8'hA0, bv(5'h00));
      chk(64'(seen[7]), 64'h0000_0000_0000_0000);
      acc(1'b1, 1'b1, `BIND_SPACE, 8'h09, bv(5'h00));
      chk(64'(seen[7]), 64'h0000_0000_0000_0000);
      wrap_up();
   end
endmodule
